// *** hdl/svi_cfg.svh ***
// Constants of the serial voltage-identification slave
`ifndef SVI_CFG_SVH
`define SVI_CFG_SVH

`define SVI_ADDR_FIXED_MSB   6
`define SVI_ADDR_FIXED_LSB   4
`define SVI_ADDR_FIXED_VALUE 3'h6
`define SVI_ADDR_RESERVED    3
`define SVI_SEL_CORE_B       2
`define SVI_SEL_CORE_A       1
`define SVI_SEL_NB           0
`define SVI_RW_BIT           0
`define SVI_RW_WRITE         1'h0
`define SVI_HINT_BIT         7
`define SVI_CODE_MSB         6
`define SVI_BYTE_BITS        4'h8
`define SVI_OFF_CODE         7'h7C
`define SVI_CODE0_MICROVOLT  1550000
`define SVI_CODE_RESET       7'h7F
`define SVI_HINT_RESET       1'h1
`define SVI_LINE_IDLE        1'h1
`define SVI_OK_RESET         1'h0

`endif

// *** hdl/svi_pkg.sv ***
// Types of the serial voltage-identification slave
package svi_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_WAIT_STOP,
        ST_IGNORE
    } link_state_type;

endpackage

// *** hdl/svi_link_sync.sv ***
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none

module svi_link_sync #(
    parameter int              WIDTH       = 10,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_sync_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // svi_link_sync

`default_nettype wire

// *** hdl/svi_plane_targets.sv ***
// Per-plane voltage target registers with off decode
`timescale 1ns/10ps
`default_nettype none
`include "svi_cfg.svh"

module svi_plane_targets #(
    parameter int PLANES = 3
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_sync_n,
    input  wire logic                clk_en,
    input  wire logic [PLANES-1:0]   load,
    input  wire logic [6:0]          code,
    input  wire logic                boot_load,
    input  wire logic [6:0]          boot_code,
    output var  logic [PLANES*7-1:0] plane_code,
    output var  logic [PLANES-1:0]   plane_off
);

    genvar g;
    generate
        for (g = 0; g < PLANES; g++) begin : g_plane
            wire logic [6:0] code_next;
            assign code_next = boot_load ? boot_code : code;  // RULE19
            always_ff @(posedge sys_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    plane_code[g*7 +: 7] <= `SVI_CODE_RESET;
                    plane_off[g]         <= 1'h1;
                end else if (clk_en && (boot_load || load[g])) begin
                    plane_code[g*7 +: 7] <= code_next;
                    plane_off[g]         <= (code_next >= `SVI_OFF_CODE);  // RULE20
                end
            end
        end
    endgenerate

    property p_off_decode;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        plane_off[0] == (plane_code[6:0] >= `SVI_OFF_CODE);
    endproperty
    a_off_decode: assert property (p_off_decode) else $error("off flag disagrees with code"); // RULE20

endmodule // svi_plane_targets

`default_nettype wire

// *** hdl/serial_voltage_id_slave.sv ***
// Serial voltage-identification send-byte slave
// Summary of operation
// RULE1: Transactions are start, address, data, stop only
// RULE2: Master sends this regulator's address after start
// RULE3: Address bits 6:4 must equal 110b
// RULE4: Address bit 3 reserved, selects nothing
// RULE5: Bit 2 selects second core plane
// RULE6: Bit 1 selects first core plane
// RULE7: Bit 0 selects northbridge; several allowed
// RULE8: Write bit follows the seven address bits
// RULE9: Acknowledge address only when it is valid
// RULE10: Data byte is hint then seven code bits
// RULE11: Data bit 7 is active-low power-saving hint
// RULE12: Data bits 6:0 are the voltage code
// RULE13: Acknowledge a complete valid data byte
// RULE14: Master ends transaction with stop after data
// RULE15: New targets applied only after stop seen
// RULE16: Start-up regulates to pin-strapped boot code
// RULE17: Commands drive power saving, targets, shutdown
// RULE18: Watch serial lines only while power-ok high
// RULE19: Power-ok low: ignore lines, restore boot code
// RULE20: Decode planes and code; 7Ch upward is off
// RULE21: Invalid bytes: no acknowledge, nothing changes
`timescale 1ns/10ps
`default_nettype none
`include "svi_cfg.svh"

module serial_voltage_id_slave
    import svi_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       cpu_power_ok,
    input  wire logic [6:0] boot_code_pins,
    input  wire logic       serial_link_clock,
    input  wire logic       serial_link_data_in,
    output var  logic       serial_link_data_out,
    output var  logic       serial_link_data_oe,
    output var  logic [6:0] core_plane_a_code,
    output var  logic       core_plane_a_off,
    output var  logic [6:0] core_plane_b_code,
    output var  logic       core_plane_b_off,
    output var  logic [6:0] northbridge_plane_code,
    output var  logic       northbridge_plane_off,
    output var  logic       power_saving_hint_n,
    output var  logic       target_update
);

    // Reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'h0;
            rst_sync_n   <= 1'h0;
        end else begin
            rst_meta_reg <= 1'h1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    // Input synchronisers: {boot pins, power-ok, data, clock}
    wire logic [9:0] async_in;
    wire logic [9:0] sync_in;

    assign async_in = {boot_code_pins, cpu_power_ok, serial_link_data_in, serial_link_clock};

    svi_link_sync #(
        .WIDTH       (10),
        .RESET_VALUE ({`SVI_CODE_RESET, `SVI_OK_RESET, `SVI_LINE_IDLE, `SVI_LINE_IDLE})
    ) u_sync (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .clk_en     (clk_en),
        .async_in   (async_in),
        .sync_out   (sync_in)
    );

    wire logic       scl_s;
    wire logic       sda_s;
    wire logic       ok_s;
    wire logic [6:0] boot_s;

    assign scl_s  = sync_in[0];
    assign sda_s  = sync_in[1];
    assign ok_s   = sync_in[2];
    assign boot_s = sync_in[9:3];

    // Line edge and condition detection
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scl_prev_reg <= `SVI_LINE_IDLE;
            sda_prev_reg <= `SVI_LINE_IDLE;
        end else if (clk_en) begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    wire logic scl_rise;
    wire logic scl_fall;
    wire logic start_det;
    wire logic stop_det;

    assign scl_rise  = scl_s & ~scl_prev_reg;
    assign scl_fall  = ~scl_s & scl_prev_reg;
    assign start_det = ok_s & scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;  // RULE18
    assign stop_det  = ok_s & scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;  // RULE18

    // Boot code sampled up to the first power-ok, then held
    logic       boot_taken_reg;
    logic [6:0] boot_reg;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            boot_taken_reg <= 1'h0;
            boot_reg       <= `SVI_CODE_RESET;
        end else if (clk_en && !boot_taken_reg) begin
            boot_reg       <= boot_s;  // RULE16
            boot_taken_reg <= ok_s;
        end
    end

    // Transaction state
    link_state_type state_reg;
    link_state_type state_next;
    logic [3:0]     count_reg;
    logic [3:0]     count_next;
    logic [7:0]     shift_reg;
    logic [7:0]     shift_next;
    logic [2:0]     planes_reg;
    logic [2:0]     planes_next;
    logic [7:0]     pend_reg;
    logic [7:0]     pend_next;
    logic           pend_valid_reg;
    logic           pend_valid_next;
    logic           oe_next;
    logic           commit_next;

    wire logic byte_done;
    wire logic addr_ok;
    wire logic [2:0] addr_planes;

    assign byte_done   = scl_fall && (count_reg == `SVI_BYTE_BITS);
    assign addr_ok     = (shift_reg[`SVI_ADDR_FIXED_MSB+1:`SVI_ADDR_FIXED_LSB+1]
                          == `SVI_ADDR_FIXED_VALUE)                        // RULE3
                         && (shift_reg[`SVI_RW_BIT] == `SVI_RW_WRITE);     // RULE8
    // Bit 3 of the address (shift bit 4) deliberately takes no part here
    assign addr_planes = {shift_reg[`SVI_SEL_CORE_B+1],                    // RULE5
                          shift_reg[`SVI_SEL_CORE_A+1],                    // RULE6
                          shift_reg[`SVI_SEL_NB+1]};                       // RULE7 RULE4

    always_comb begin
        state_next      = state_reg;
        count_next      = count_reg;
        shift_next      = shift_reg;
        planes_next     = planes_reg;
        pend_next       = pend_reg;
        pend_valid_next = pend_valid_reg;
        oe_next         = serial_link_data_oe;
        commit_next     = 1'h0;
        if (!ok_s) begin
            state_next      = ST_IDLE;  // RULE19
            oe_next         = 1'h0;
            pend_valid_next = 1'h0;
        end else if (start_det) begin
            state_next      = ST_ADDR;  // RULE2
            count_next      = 4'h0;
            oe_next         = 1'h0;
            pend_valid_next = 1'h0;
        end else if (stop_det) begin
            state_next      = ST_IDLE;
            oe_next         = 1'h0;
            commit_next     = pend_valid_reg && (state_reg == ST_WAIT_STOP);  // RULE15 RULE14
            pend_valid_next = 1'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_IGNORE: begin
                    oe_next = 1'h0;
                end
                ST_ADDR, ST_DATA: begin
                    if (scl_rise && count_reg < `SVI_BYTE_BITS) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        count_next = count_reg + 4'h1;
                    end
                    if (byte_done && state_reg == ST_ADDR) begin
                        if (addr_ok) begin
                            state_next  = ST_ADDR_ACK;
                            oe_next     = 1'h1;  // RULE9
                            planes_next = addr_planes;
                        end else begin
                            state_next = ST_IGNORE;  // RULE21
                        end
                    end else if (byte_done) begin
                        state_next = ST_DATA_ACK;
                        oe_next    = 1'h1;  // RULE13
                        pend_next  = shift_reg;  // RULE10
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_next = ST_DATA;
                        oe_next    = 1'h0;
                        count_next = 4'h0;
                    end
                end
                ST_DATA_ACK: begin
                    if (scl_fall) begin
                        state_next      = ST_WAIT_STOP;
                        oe_next         = 1'h0;
                        pend_valid_next = 1'h1;
                    end
                end
                ST_WAIT_STOP: begin
                    // The stop needs one clock rise; a further fall means more bits
                    if (scl_fall) begin
                        state_next      = ST_IGNORE;  // RULE1 RULE21
                        pend_valid_next = 1'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg           <= ST_IDLE;
            count_reg           <= 4'h0;
            shift_reg           <= 8'h00;
            planes_reg          <= 3'h0;
            pend_reg            <= 8'hFF;
            pend_valid_reg      <= 1'h0;
            serial_link_data_oe <= 1'h0;
            target_update       <= 1'h0;
        end else if (clk_en) begin
            state_reg           <= state_next;
            count_reg           <= count_next;
            shift_reg           <= shift_next;
            planes_reg          <= planes_next;
            pend_reg            <= pend_next;
            pend_valid_reg      <= pend_valid_next;
            serial_link_data_oe <= oe_next;
            target_update       <= commit_next;
        end
    end

    // Acknowledge only ever pulls the line low
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            serial_link_data_out <= 1'h0;
        end else if (clk_en) begin
            serial_link_data_out <= 1'h0;
        end
    end

    // Power-saving hint follows committed commands only
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            power_saving_hint_n <= `SVI_HINT_RESET;
        end else if (clk_en && target_update) begin
            power_saving_hint_n <= pend_reg[`SVI_HINT_BIT];  // RULE11 RULE17
        end
    end

    // Plane targets: index 0 northbridge, 1 core a, 2 core b
    wire logic [2:0]  plane_load;
    wire logic [20:0] plane_code;
    wire logic [2:0]  plane_off;

    assign plane_load = planes_reg & {3{target_update}};  // RULE15 RULE17

    svi_plane_targets #(
        .PLANES (3)
    ) u_targets (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .clk_en     (clk_en),
        .load       (plane_load),
        .code       (pend_reg[`SVI_CODE_MSB:0]),  // RULE12
        .boot_load  (!ok_s),  // RULE16 RULE19
        .boot_code  (boot_reg),
        .plane_code (plane_code),
        .plane_off  (plane_off)
    );

    assign northbridge_plane_code = plane_code[6:0];
    assign core_plane_a_code      = plane_code[13:7];
    assign core_plane_b_code      = plane_code[20:14];
    assign northbridge_plane_off  = plane_off[0];
    assign core_plane_a_off       = plane_off[1];
    assign core_plane_b_off       = plane_off[2];

    // Checks
    sequence s_stop_seen;
        stop_det && state_reg == ST_WAIT_STOP && pend_valid_reg;
    endsequence

    property p_commit_after_stop;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        target_update |-> $past(stop_det) && $past(state_reg) == ST_WAIT_STOP;
    endproperty
    a_commit_after_stop: assert property (p_commit_after_stop) else $error("update without stop"); // RULE15

    property p_stop_commits;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        s_stop_seen |=> target_update;
    endproperty
    a_stop_commits: assert property (p_stop_commits) else $error("stop did not commit"); // RULE14

    property p_addr_ack_valid;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        $rose(serial_link_data_oe) && state_reg == ST_ADDR_ACK
            |-> shift_reg[7:5] == 3'h6 && !shift_reg[0];
    endproperty
    a_addr_ack_valid: assert property (p_addr_ack_valid) else $error("bad address acked"); // RULE9

    property p_bad_addr_no_ack;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        state_reg == ST_ADDR && byte_done && ok_s && !start_det && !stop_det && !addr_ok
            |=> state_reg == ST_IGNORE ##1 !serial_link_data_oe;
    endproperty
    a_bad_addr_no_ack: assert property (p_bad_addr_no_ack) else $error("bad address acked"); // RULE21

    property p_data_ack;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        state_reg == ST_DATA && byte_done && ok_s && !start_det && !stop_det
            |=> serial_link_data_oe && !serial_link_data_out;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("data byte not acked"); // RULE13

    property p_quiet_when_not_ok;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        !ok_s |=> !serial_link_data_oe && !target_update;
    endproperty
    a_quiet_when_not_ok: assert property (p_quiet_when_not_ok) else $error("active without power-ok"); // RULE18

    property p_boot_restore;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        !ok_s && boot_taken_reg |=> core_plane_a_code == boot_reg
            && core_plane_b_code == boot_reg && northbridge_plane_code == boot_reg;
    endproperty
    a_boot_restore: assert property (p_boot_restore) else $error("boot code not restored"); // RULE19

    property p_plane_nb_load;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        target_update && planes_reg[0] && ok_s
            |=> northbridge_plane_code == $past(pend_reg[6:0]);
    endproperty
    a_plane_nb_load: assert property (p_plane_nb_load) else $error("northbridge not loaded"); // RULE7

    property p_plane_b_hold;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        target_update && !planes_reg[2] && ok_s |=> $stable(core_plane_b_code);
    endproperty
    a_plane_b_hold: assert property (p_plane_b_hold) else $error("unselected plane changed"); // RULE5

    property p_hint_on_commit;
        @(posedge sys_clk) disable iff (!rst_sync_n || !clk_en)
        $changed(power_saving_hint_n) |-> $past(target_update);
    endproperty
    a_hint_on_commit: assert property (p_hint_on_commit) else $error("hint changed outside commit"); // RULE11

endmodule // serial_voltage_id_slave

`default_nettype wire

// *** tb/svi_bus_master.sv ***
// Behavioural link master that frames send-byte commands
`timescale 1ns/10ps
`default_nettype none

module svi_bus_master (
    input  wire logic link_data,
    output var  logic serial_link_clock,
    output var  logic data_low
);
    localparam int HALF = 200;

    // Clock stands high and data is released between frames
    initial begin
        serial_link_clock = 1'h1;
        data_low          = 1'h0;
    end

    task automatic start_cond();
        #HALF;
        data_low = 1'h1;
        #(HALF / 2);
        serial_link_clock = 1'h0;
        #(HALF / 2);
    endtask

    // Msb first; data moves only mid-low so no false start or stop
    task automatic send_byte(input logic [7:0] value, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            data_low = ~value[i];
            #(HALF / 2);
            serial_link_clock = 1'h1;
            #HALF;
            serial_link_clock = 1'h0;
            #(HALF / 2);
        end
        data_low = 1'h0;
        #(HALF / 2);
        serial_link_clock = 1'h1;
        #(HALF / 2);
        ack = ~link_data;
        #(HALF / 2);
        serial_link_clock = 1'h0;
        #(HALF / 2);
    endtask

    task automatic stop_cond();
        data_low = 1'h1;
        #(HALF / 2);
        serial_link_clock = 1'h1;
        #(HALF / 2);
        data_low = 1'h0;
        #HALF;
    endtask
endmodule // svi_bus_master

`default_nettype wire

// *** tb/serial_voltage_id_slave_tb_top.sv ***
// Self-checking bench of the voltage-identification slave
`timescale 1ns/10ps
`default_nettype none

module serial_voltage_id_slave_tb_top;
    logic       sys_clk;
    logic       rst_n;
    logic       clk_en;
    logic       cpu_power_ok;
    logic [6:0] boot_code_pins;
    logic       serial_link_clock;
    logic       data_low;
    logic       data_out;
    logic       data_oe;
    wire logic  link_data;
    logic [6:0] a_code;
    logic [6:0] b_code;
    logic [6:0] nb_code;
    logic       a_off;
    logic       b_off;
    logic       nb_off;
    logic       hint_n;
    logic       target_update;
    logic [6:0] exp_a;
    logic [6:0] exp_b;
    logic [6:0] exp_nb;
    logic       exp_hint;
    int         err_total;
    int         checks;
    int         upd_count;
    logic [7:0] addr_tab [8];
    logic [7:0] data_tab [8];

    // Pulled-up wire, low when either party pulls it
    assign link_data = ~(data_low | (data_oe & ~data_out));

    initial sys_clk = 1'h0;
    always #25 sys_clk = ~sys_clk;

    serial_voltage_id_slave dut_u (
        .sys_clk               (sys_clk),
        .rst_n                 (rst_n),
        .clk_en                (clk_en),
        .cpu_power_ok          (cpu_power_ok),
        .boot_code_pins        (boot_code_pins),
        .serial_link_clock     (serial_link_clock),
        .serial_link_data_in   (link_data),
        .serial_link_data_out  (data_out),
        .serial_link_data_oe   (data_oe),
        .core_plane_a_code     (a_code),
        .core_plane_a_off      (a_off),
        .core_plane_b_code     (b_code),
        .core_plane_b_off      (b_off),
        .northbridge_plane_code(nb_code),
        .northbridge_plane_off (nb_off),
        .power_saving_hint_n   (hint_n),
        .target_update         (target_update)
    );

    svi_bus_master master_u (
        .link_data        (link_data),
        .serial_link_clock(serial_link_clock),
        .data_low         (data_low)
    );

    always @(negedge sys_clk) begin
        if (target_update === 1'h1) begin
            upd_count++;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        checks++;
        if (seen !== expected) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expected);
        end
    endtask

    task automatic check_outputs();
        check({1'h0, a_code}, {1'h0, exp_a});
        check({1'h0, b_code}, {1'h0, exp_b});
        check({1'h0, nb_code}, {1'h0, exp_nb});
        check({7'h0, a_off}, {7'h0, exp_a >= 7'h7C});
        check({7'h0, b_off}, {7'h0, exp_b >= 7'h7C});
        check({7'h0, nb_off}, {7'h0, exp_nb >= 7'h7C});
    endtask

    task automatic final_report();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One send-byte frame; acceptance is worked out from the address byte and power-ok
    task automatic cmd(input logic [7:0] abyte, input logic [7:0] dbyte);
        logic ack_a;
        logic ack_d;
        logic ok;
        int   pulses;
        ok = (abyte[7:5] === 3'h6) && (abyte[0] === 1'h0) && (cpu_power_ok === 1'h1);
        pulses = upd_count;
        master_u.start_cond();
        master_u.send_byte(abyte, ack_a);
        check({7'h0, ack_a}, {7'h0, ok});
        master_u.send_byte(dbyte, ack_d);
        check({7'h0, ack_d}, {7'h0, ok});
        repeat (3) @(negedge sys_clk);
        check_outputs();
        check(8'(upd_count), 8'(pulses));
        master_u.stop_cond();
        repeat (8) @(negedge sys_clk);
        if (ok) begin
            exp_nb = abyte[1] ? dbyte[6:0] : exp_nb;
            exp_a = abyte[2] ? dbyte[6:0] : exp_a;
            exp_b = abyte[3] ? dbyte[6:0] : exp_b;
            exp_hint = dbyte[7];
        end
        check_outputs();
        check({7'h0, hint_n}, {7'h0, exp_hint});
        check(8'(upd_count), 8'(pulses + int'(ok)));
    endtask

    initial begin
        #1ms;
        err_total++;
        final_report();
    end

    initial begin
        addr_tab = '{8'hC2, 8'hC4, 8'hC8, 8'hCE, 8'hD4, 8'hC0, 8'hA2, 8'hC3};
        data_tab = '{8'h00, 8'h81, 8'h7B, 8'h7C, 8'h3F, 8'h80, 8'h05, 8'h06};
        err_total = 0;
        checks = 0;
        upd_count = 0;
        rst_n = 1'h0;
        clk_en = 1'h1;
        cpu_power_ok = 1'h0;
        boot_code_pins = 7'h12;
        exp_a = 7'h7F;
        exp_b = 7'h7F;
        exp_nb = 7'h7F;
        exp_hint = 1'h1;
        repeat (16) @(negedge sys_clk);
        check_outputs();
        check({7'h0, hint_n}, {7'h0, exp_hint});
        check({7'h0, data_oe}, 8'h00);
        rst_n = 1'h1;
        repeat (10) @(negedge sys_clk);
        exp_a = 7'h12;
        exp_b = 7'h12;
        exp_nb = 7'h12;
        check_outputs();
        // Lines are ignored before power-ok
        cmd(8'hCE, 8'h05);
        cpu_power_ok = 1'h1;
        repeat (8) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            cmd(addr_tab[i], data_tab[i]);
        end
        // Strap moves after capture; a frozen block ignores power-ok loss
        boot_code_pins = 7'h30;
        repeat (4) @(negedge sys_clk);
        clk_en = 1'h0;
        cpu_power_ok = 1'h0;
        repeat (8) @(negedge sys_clk);
        check_outputs();
        clk_en = 1'h1;
        repeat (8) @(negedge sys_clk);
        exp_a = 7'h12;
        exp_b = 7'h12;
        exp_nb = 7'h12;
        check_outputs();
        cmd(8'hC4, 8'h22);
        final_report();
    end
endmodule // serial_voltage_id_slave_tb_top

`default_nettype wire
